// >>> design/sinc_decimator_overrange.sv
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module sinc_decimator_overrange (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [sinc_pkg::channels-1:0] mod_bit,
	input wire logic [sinc_pkg::channels-1:0] mod_strobe,
	output logic [sinc_pkg::channels-1:0] dma_req,
	input wire logic [sinc_pkg::channels-1:0] dma_ack,
	output logic [sinc_pkg::channels-1:0][31:0] dma_data,
	output logic [sinc_pkg::channels-1:0] trigger_out,
	output logic fault_out,
	output logic irq
);
	import sinc_pkg::*;
	bus_state_type state, next_state;
	logic [7:0] addr, next_addr;
	logic [31:0] next_hrdata;
	logic [ctrl_width-1:0] ctrl, next_ctrl, wdata_ctrl;
	logic [status_width-1:0] status, next_status, mask, next_mask;
	logic [status_width-1:0] events, clear;
	logic [8:0] pri_ratio [channels];
	logic [8:0] next_pri_ratio [channels];
	logic [8:0] sec_ratio [channels];
	logic [8:0] next_sec_ratio [channels];
	logic signed [31:0] pos_lim [channels];
	logic signed [31:0] next_pos_lim [channels];
	logic signed [31:0] neg_lim [channels];
	logic signed [31:0] next_neg_lim [channels];
	logic [31:0] result [channels];
	logic [31:0] next_result [channels];
	logic signed [acc_width-1:0] pri_res [channels];
	logic signed [acc_width-1:0] sec_res [channels];
	logic signed [31:0] pri_sat [channels];
	logic signed [31:0] sec_sat [channels];
	logic [channels-1:0] pending, next_pending, consume, ovr_ev;
	logic [channels-1:0] pos_ev, neg_ev, pri_valid, sec_valid;
	logic [channels-1:0] next_trigger;
	logic next_fault, next_irq, accept, wr, chan_hit;
	logic [1:0] chan;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	assign hresp = 1'b0;
	assign hreadyout = (state != bus_rdwait);
	assign dma_req = pending;
	assign wdata_ctrl = hwdata[ctrl_width-1:0];

	for (genvar c = 0; c < channels; c++) begin : g_ch
		sinc_stage u_primary (
			.hclk(hclk),
			.hresetn(hresetn),
			.enable(ctrl[ctrl_en_lsb+c]),
			.bit_valid(mod_strobe[c]),
			.bit_in(mod_bit[c]),
			.order4(ctrl[ctrl_pord_lsb+c]),
			.ratio(pri_ratio[c]),
			.result(pri_res[c]),
			.result_valid(pri_valid[c])
		);
		sinc_stage u_secondary (
			.hclk(hclk),
			.hresetn(hresetn),
			.enable(ctrl[ctrl_en_lsb+c]),
			.bit_valid(mod_strobe[c]),
			.bit_in(mod_bit[c]),
			.order4(ctrl[ctrl_sord_lsb+c]),
			.ratio(sec_ratio[c]),
			.result(sec_res[c]),
			.result_valid(sec_valid[c])
		);
		assign pri_sat[c] = sat32(pri_res[c]);
		assign sec_sat[c] = sat32(sec_res[c]);
		assign pos_ev[c] = sec_valid[c] && (sec_sat[c] > pos_lim[c]);
		assign neg_ev[c] = sec_valid[c] && (sec_sat[c] < neg_lim[c]);
		assign dma_data[c] = result[c];

		a_pos_limit: assert property (
			sec_valid[c] && sec_sat[c] > pos_lim[c] |=> status[st_pos_lsb+c])
			else $error("positive over-range not flagged");
		a_neg_limit: assert property (
			sec_valid[c] && sec_sat[c] < neg_lim[c] |=> status[st_neg_lsb+c])
			else $error("negative over-range not flagged");
		a_trigger_pulse: assert property (
			(pos_ev[c] || neg_ev[c]) && ctrl[ctrl_trig_lsb+c]
			|=> trigger_out[c] ##1 !trigger_out[c])
			else $error("trigger pulse missing or too long");
		a_dma_result: assert property (
			pri_valid[c] |=> dma_req[c] && dma_data[c] == $past(pri_sat[c]))
			else $error("primary result not offered to DMA");
		a_ratio_range: assert property (
			pri_ratio[c] >= ratio_min && pri_ratio[c] <= ratio_max)
			else $error("primary ratio out of range");
	end

	always_comb begin
		accept = hsel && hready && htrans[1];
		wr = (state == bus_write);
		chan_hit = (addr[7:4] >= ch_first) && (addr[7:4] <= ch_last);
		chan = 2'(addr[7:4] - ch_first);
		next_state = state;
		next_addr = addr;
		next_hrdata = hrdata;
		next_ctrl = ctrl;
		next_mask = mask;
		next_pri_ratio = pri_ratio;
		next_sec_ratio = sec_ratio;
		next_pos_lim = pos_lim;
		next_neg_lim = neg_lim;
		next_result = result;
		next_pending = pending;
		clear = '0;
		consume = '0;
		ovr_ev = '0;
		unique case (state)
			bus_idle, bus_write, bus_rddone: begin
				if (accept) begin
					next_addr = haddr[7:0];
					next_state = hwrite ? bus_write : bus_rdwait;
				end else begin
					next_state = bus_idle;
				end
			end
			bus_rdwait: begin
				next_state = bus_rddone;
			end
			default: begin
				next_state = bus_idle;
			end
		endcase
		if (wr) begin
			if (addr == ctrl_off) begin
				next_ctrl = wdata_ctrl;
			end else if (addr == status_off) begin
				clear = hwdata[status_width-1:0];
			end else if (addr == mask_off) begin
				next_mask = hwdata[status_width-1:0];
			end else if (chan_hit) begin
				if (addr[3:0] == ratio_off) begin
					next_pri_ratio[chan] = clamp_ratio(hwdata[15:0], ratio_min);
					next_sec_ratio[chan] = clamp_ratio(hwdata[31:16], sec_ratio_min);
				end else if (addr[3:0] == pos_off) begin
					next_pos_lim[chan] = hwdata;
				end else if (addr[3:0] == neg_off) begin
					next_neg_lim[chan] = hwdata;
				end
			end
		end
		if (state == bus_rdwait) begin
			next_hrdata = 32'h00000000;
			if (addr == ctrl_off) begin
				next_hrdata = {{(32-ctrl_width){1'b0}}, ctrl};
			end else if (addr == status_off) begin
				next_hrdata = {{(32-status_width){1'b0}}, status};
			end else if (addr == mask_off) begin
				next_hrdata = {{(32-status_width){1'b0}}, mask};
			end else if (chan_hit) begin
				if (addr[3:0] == ratio_off) begin
					next_hrdata = {7'h00, sec_ratio[chan], 7'h00, pri_ratio[chan]};
				end else if (addr[3:0] == pos_off) begin
					next_hrdata = pos_lim[chan];
				end else if (addr[3:0] == neg_off) begin
					next_hrdata = neg_lim[chan];
				end else begin
					next_hrdata = result[chan];
					consume[chan] = 1'b1;
				end
			end
		end
		for (int c = 0; c < channels; c++) begin
			if (pri_valid[c]) begin
				ovr_ev[c] = pending[c] && !dma_ack[c] && !consume[c];
				next_pending[c] = 1'b1;
				next_result[c] = pri_sat[c];
			end else if (consume[c] || dma_ack[c] || !ctrl[ctrl_en_lsb+c]) begin
				next_pending[c] = 1'b0;
			end
		end
		events = {ovr_ev, neg_ev, pos_ev};
		next_status = (status & ~clear) | events;
		next_trigger = (pos_ev | neg_ev) & ctrl[ctrl_trig_lsb +: channels];
		next_fault = |((next_status[st_pos_lsb +: channels]
			| next_status[st_neg_lsb +: channels])
			& ctrl[ctrl_fault_lsb +: channels]);
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= bus_idle;
			addr <= 8'h00;
			hrdata <= 32'h00000000;
			ctrl <= ctrl_reset;
			status <= status_reset;
			mask <= status_reset;
			for (int c = 0; c < channels; c++) begin
				pri_ratio[c] <= pri_ratio_reset;
				sec_ratio[c] <= sec_ratio_reset;
				pos_lim[c] <= pos_lim_reset;
				neg_lim[c] <= neg_lim_reset;
				result[c] <= 32'h00000000;
			end
			pending <= '0;
			trigger_out <= '0;
			fault_out <= 1'b0;
			irq <= 1'b0;
		end else begin
			state <= next_state;
			addr <= next_addr;
			hrdata <= next_hrdata;
			ctrl <= next_ctrl;
			status <= next_status;
			mask <= next_mask;
			pri_ratio <= next_pri_ratio;
			sec_ratio <= next_sec_ratio;
			pos_lim <= next_pos_lim;
			neg_lim <= next_neg_lim;
			result <= next_result;
			pending <= next_pending;
			trigger_out <= next_trigger;
			fault_out <= next_fault;
			irq <= next_irq;
		end
	end

	sequence s_read_addr;
		hsel && hready && hreadyout && htrans[1] && !hwrite;
	endsequence
	sequence s_write_ctrl;
		hsel && hready && hreadyout && htrans[1] && hwrite
			&& haddr[7:0] == ctrl_off;
	endsequence

	a_read_wait: assert property (
		s_read_addr |=> !hreadyout ##1 hreadyout)
		else $error("read did not take exactly one wait state");
	a_ctrl_write: assert property (
		s_write_ctrl ##1 hreadyout |=> ctrl == $past(wdata_ctrl))
		else $error("control write not stored");
	a_irq_level: assert property (irq == (|(status & mask)))
		else $error("interrupt does not follow masked status");
endmodule

// >>> design/sinc_stage.sv
`timescale 1ns/1ps
module sinc_stage (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic enable,
	input wire logic bit_valid,
	input wire logic bit_in,
	input wire logic order4,
	input wire logic [8:0] ratio,
	output logic signed [sinc_pkg::acc_width-1:0] result,
	output logic result_valid
);
	import sinc_pkg::*;
	logic signed [acc_width-1:0] integ [max_order];
	logic signed [acc_width-1:0] next_integ [max_order];
	logic signed [acc_width-1:0] delay [max_order];
	logic signed [acc_width-1:0] next_delay [max_order];
	logic signed [acc_width-1:0] comb [max_order];
	logic signed [acc_width-1:0] tap;
	logic signed [acc_width-1:0] next_result;
	logic [8:0] count;
	logic [8:0] next_count;
	logic next_valid;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// Integrators run at the bit rate, combs at the decimated rate.
	always_comb begin
		next_integ = integ;
		next_delay = delay;
		next_count = count;
		next_result = result;
		next_valid = 1'b0;
		tap = order4 ? integ[max_order-1] : integ[max_order-2];
		comb[0] = tap - delay[0];
		for (int i = 1; i < max_order; i++) begin
			comb[i] = comb[i-1] - delay[i];
		end
		if (!enable) begin
			for (int i = 0; i < max_order; i++) begin
				next_integ[i] = '0;
				next_delay[i] = '0;
			end
			next_count = 9'h000;
		end else if (bit_valid) begin
			next_integ[0] = integ[0] + (bit_in ? acc_one : acc_minus_one);
			for (int i = 1; i < max_order; i++) begin
				next_integ[i] = integ[i] + integ[i-1];
			end
			if (count >= ratio - 9'h001) begin
				next_count = 9'h000;
				next_delay[0] = tap;
				for (int i = 1; i < max_order; i++) begin
					next_delay[i] = comb[i-1];
				end
				next_result = order4 ? comb[max_order-1] : comb[max_order-2];
				next_valid = 1'b1;
			end else begin
				next_count = count + 9'h001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < max_order; i++) begin
				integ[i] <= '0;
				delay[i] <= '0;
			end
			count <= 9'h000;
			result <= '0;
			result_valid <= 1'b0;
		end else begin
			integ <= next_integ;
			delay <= next_delay;
			count <= next_count;
			result <= next_result;
			result_valid <= next_valid;
		end
	end

	a_decim_gap: assert property (result_valid |=> !result_valid)
		else $error("decimated results came back to back");
	a_count_bound: assert property (count < ratio_max)
		else $error("decimation counter ran past its range");
	a_idle_quiet: assert property (!enable |=> !result_valid)
		else $error("disabled filter produced a result");
endmodule

// >>> include/sinc_pkg.sv
package sinc_pkg;
	localparam int channels = 4;
	localparam int acc_width = 34;
	localparam int max_order = 4;
	localparam int ctrl_width = 20;
	localparam int status_width = 12;
	localparam logic [8:0] ratio_min = 9'h008;
	localparam logic [8:0] ratio_max = 9'h100;
	localparam logic [8:0] sec_ratio_min = 9'h002;
	localparam logic [8:0] pri_ratio_reset = 9'h040;
	localparam logic [8:0] sec_ratio_reset = 9'h010;
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] status_off = 8'h04;
	localparam logic [7:0] mask_off = 8'h08;
	localparam logic [3:0] ch_first = 4'h1;
	localparam logic [3:0] ch_last = 4'h4;
	localparam logic [3:0] ratio_off = 4'h0;
	localparam logic [3:0] pos_off = 4'h4;
	localparam logic [3:0] neg_off = 4'h8;
	localparam logic [3:0] result_off = 4'hc;
	localparam int ctrl_en_lsb = 0;
	localparam int ctrl_pord_lsb = 4;
	localparam int ctrl_sord_lsb = 8;
	localparam int ctrl_trig_lsb = 12;
	localparam int ctrl_fault_lsb = 16;
	localparam int st_pos_lsb = 0;
	localparam int st_neg_lsb = 4;
	localparam int st_ovr_lsb = 8;
	localparam logic [ctrl_width-1:0] ctrl_reset = 20'h00000;
	localparam logic [status_width-1:0] status_reset = 12'h000;
	localparam logic signed [31:0] pos_lim_reset = 32'sh7fffffff;
	localparam logic signed [31:0] neg_lim_reset = 32'sh80000000;
	localparam logic signed [acc_width-1:0] acc_one = 34'sh000000001;
	localparam logic signed [acc_width-1:0] acc_minus_one = 34'sh3ffffffff;
	localparam logic signed [acc_width-1:0] sat_hi = 34'sh07fffffff;
	localparam logic signed [acc_width-1:0] sat_lo = 34'sh380000000;

	typedef enum logic [3:0] {
		bus_idle = 4'h1,
		bus_write = 4'h2,
		bus_rdwait = 4'h4,
		bus_rddone = 4'h8
	} bus_state_type;

	function automatic logic signed [31:0] sat32(
		input logic signed [acc_width-1:0] v);
		if (v > sat_hi) begin
			return pos_lim_reset;
		end
		if (v < sat_lo) begin
			return neg_lim_reset;
		end
		return v[31:0];
	endfunction

	function automatic logic [8:0] clamp_ratio(input logic [15:0] v,
		input logic [8:0] lo);
		if (v < {7'h00, lo}) begin
			return lo;
		end
		if (v > {7'h00, ratio_max}) begin
			return ratio_max;
		end
		return v[8:0];
	endfunction
endpackage

// >>> verification/mod_model.sv
`timescale 1ns/1ps
module mod_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [3:0] run,
	input wire logic [3:0] level,
	input wire logic slow,
	output logic [3:0] mod_bit,
	output logic [3:0] mod_strobe
);
	logic phase;
	// Each stream whose run bit is set strobes every cycle, or every other cycle
	// when slow; between strobes the bit shows the inverse level.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase <= 1'b0;
			mod_strobe <= 4'h0;
			mod_bit <= 4'h0;
		end else begin
			phase <= ~phase;
			mod_strobe <= (phase | ~slow) ? run : 4'h0;
			mod_bit <= (phase | ~slow) ? level : ~level;
		end
	end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import sinc_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fault_out, irq;
	logic slow;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] mod_bit, mod_strobe, dma_req, dma_ack, trigger_out;
	logic [3:0] run, level;
	logic [3:0][31:0] dma_data;
	int errors, n_checks;

	sinc_decimator_overrange dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.mod_bit(mod_bit), .mod_strobe(mod_strobe), .dma_req(dma_req),
		.dma_ack(dma_ack), .dma_data(dma_data), .trigger_out(trigger_out),
		.fault_out(fault_out), .irq(irq));
	mod_model partner (.hclk(hclk), .hresetn(hresetn), .run(run),
		.level(level), .slow(slow), .mod_bit(mod_bit),
		.mod_strobe(mod_strobe));

	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end

	task automatic stop_test();
		$display("errors=%0d checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e, "register read");
	endtask

	task automatic wait_on(input logic trig, input int c);
		int t;
		t = 0;
		while ((trig ? trigger_out[c] : dma_req[c]) !== 1'b1 && t < 4000) begin
			@(posedge hclk);
			t++;
		end
		chk(trig ? trigger_out[c] : dma_req[c], 1'b1, "event wait");
	endtask

	task automatic regs();
		chk({dma_req, trigger_out, fault_out, irq, hresp}, 0, "reset out");
		rd(ctrl_off, 32'h0);
		rd(status_off, 32'h0);
		rd(mask_off, 32'h0);
		rd(8'h10, 32'h00100040);
		rd(8'h34, 32'h7fffffff);
		rd(8'h48, 32'h80000000);
		bus(1'b1, 8'h80, 32'hffffffff);
		rd(8'h80, 32'h0);
		bus(1'b1, 8'h1c, 32'h1234);
		rd(8'h1c, 32'h0);
		bus(1'b1, 8'h10, 32'h4);
		rd(8'h10, 32'h00020008);
		bus(1'b1, 8'h10, 32'h01ff01ff);
		rd(8'h10, 32'h01000100);
	endtask

	task automatic primary(input logic [8:0] r, input logic o,
		input logic lv, input logic [31:0] e);
		bus(1'b1, ctrl_off, 32'h0);
		bus(1'b1, 8'h10, {16'h0010, 7'h0, r});
		level[0] <= lv;
		slow <= 1'b1;
		bus(1'b1, ctrl_off, {27'h0, o, 4'h1});
		run[0] <= 1'b1;
		repeat (5) begin
			wait_on(1'b0, 0);
			dma_ack[0] <= 1'b1;
			@(posedge hclk);
			dma_ack[0] <= 1'b0;
			@(posedge hclk);
			chk(dma_req[0], 1'b0, "ack clears");
		end
		wait_on(1'b0, 0);
		chk(dma_data[0], e, "dma data");
		run[0] <= 1'b0;
		rd(8'h1c, e);
		@(posedge hclk);
		chk(dma_req[0], 1'b0, "read clears");
	endtask

	task automatic overrange(input logic lv, input int b);
		bus(1'b1, 8'h20, 32'h00020008);
		bus(1'b1, 8'h24, 32'h00000004);
		bus(1'b1, 8'h28, 32'hfffffffc);
		level[1] <= lv;
		slow <= 1'b0;
		bus(1'b1, ctrl_off, 32'h00022002);
		run[1] <= 1'b1;
		wait_on(1'b1, 1);
		chk(irq, 1'b0, "masked irq");
		chk(fault_out, 1'b1, "fault");
		@(posedge hclk);
		chk(trigger_out[1], 1'b0, "trigger pulse");
		bus(1'b1, mask_off, 32'h1 << b);
		@(posedge hclk);
		chk(irq, 1'b1, "unmasked irq");
		run[1] <= 1'b0;
		bus(1'b0, status_off, 32'h0);
		chk(q[b], 1'b1, "limit side");
		chk(q[b ^ 4], 1'b0, "other side");
		bus(1'b1, ctrl_off, 32'h0);
		bus(1'b1, status_off, 32'hfff);
		@(posedge hclk);
		chk({irq, fault_out}, 0, "cleared");
		rd(status_off, 32'h0);
		bus(1'b1, mask_off, 32'h0);
	endtask

	task automatic quad();
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, 8'(16 * c + 16), 32'h00080008);
		end
		bus(1'b1, 8'h28, 32'hfffffc18);
		bus(1'b1, mask_off, 32'h00000f00);
		level <= 4'h5;
		slow <= 1'b1;
		bus(1'b1, ctrl_off, 32'h00000f3f);
		run <= 4'hf;
		repeat (5) begin
			wait_on(1'b0, 3);
			chk(dma_req, 4'hf, "all channels ready");
			dma_ack <= 4'hf;
			@(posedge hclk);
			dma_ack <= 4'h0;
			@(posedge hclk);
			chk(dma_req, 4'h0, "all acks clear");
		end
		wait_on(1'b0, 3);
		chk(dma_data[0], 32'h00001000, "ch0 order 4");
		chk(dma_data[1], 32'hfffff000, "ch1 order 4");
		chk(dma_data[2], 32'h00000200, "ch2 order 3");
		chk(dma_data[3], 32'hfffffe00, "ch3 order 3");
		chk(irq, 1'b0, "no overrun yet");
		repeat (20) @(posedge hclk);
		chk(irq, 1'b1, "overrun irq");
		chk(trigger_out, 4'h0, "triggers off");
		run <= 4'h0;
		bus(1'b1, ctrl_off, 32'h0);
		rd(status_off, 32'h00000f20);
		chk(dma_req, 4'h0, "disable clears");
		bus(1'b1, status_off, 32'hfff);
		bus(1'b1, mask_off, 32'h0);
		rd(status_off, 32'h0);
		chk(irq, 1'b0, "irq cleared");
	endtask

	initial begin
		#400000;
		errors++;
		stop_test();
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		dma_ack = 4'h0;
		run = 4'h0;
		level = 4'h0;
		slow = 1'b0;
		errors = 0;
		n_checks = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		regs();
		primary(9'h008, 1'b0, 1'b1, 32'h00000200);
		primary(9'h008, 1'b0, 1'b0, 32'hfffffe00);
		primary(9'h008, 1'b1, 1'b1, 32'h00001000);
		primary(9'h100, 1'b0, 1'b1, 32'h01000000);
		primary(9'h100, 1'b1, 1'b1, 32'h7fffffff);
		primary(9'h100, 1'b1, 1'b0, 32'h80000000);
		overrange(1'b1, 1);
		overrange(1'b0, 5);
		quad();
		stop_test();
	end
endmodule
